//--- mem_space_pkg.sv
/*
  Package for the memory space decoder: space codes, access classes, address
  limits, pointer widths and machine cycle timing.
  Assumes a single core clock; included by both design files.
*/
package mem_space_pkg;

  // ----------------------------------------------------------------
  // widths
  // ----------------------------------------------------------------
  localparam int PC_WIDTH = 23;
  localparam int EXTENDED_DATA_POINTER_WIDTH = 23;
  localparam int DATA_POINTER_16_WIDTH = 16;
  localparam int SP_WIDTH = 16;
  localparam int ADDR_WIDTH = 23;

  // ----------------------------------------------------------------
  // limits
  // ----------------------------------------------------------------
  localparam logic [22:0] DIRECT_TOP = 23'h00007f;
  localparam logic [22:0] INDIRECT_TOP = 23'h0000ff;
  localparam int EXTENDED_INTERNAL_SPACE_BYTES = 1280;
  localparam int XRAM_BYTES_SMALL = 768;
  localparam int XRAM_BYTES_LARGE = 1792;
  localparam logic [22:0] EXTERNAL_DATA_SPACE_TOP = 23'h00ffff;
  localparam logic [22:0] HIGH_DATA_SPACE_BYTES = 23'h7f0000;
  localparam logic [22:0] SP_RESET = 23'h000007;

  // universal pointer: bit 22 set selects data, 7f0000-7f04ff is internal ram
  localparam logic [22:0] UPTR_EXTENDED_INTERNAL_SPACE_BASE = 23'h7f0000;

  // ----------------------------------------------------------------
  // timing
  // ----------------------------------------------------------------
  localparam int CLOCKS_PER_MCYCLE = 6;
  localparam logic [2:0] MCYCLE_LAST = 3'h5;

  // ----------------------------------------------------------------
  // enumerations
  // ----------------------------------------------------------------
  typedef enum logic [2:0] {
    ACC_DIRECT,
    ACC_INDIRECT,
    ACC_STACK,
    ACC_EXT_MOVE,
    ACC_CODE_MOVE,
    ACC_FETCH,
    ACC_UNIVERSAL
  } access_class_t;

  typedef enum logic [1:0] {
    PTR_DPTR16,
    PTR_REG_ZERO,
    PTR_REG_ONE,
    PTR_EXTENDED
  } pointer_sel_t;

  typedef enum logic [2:0] {
    SPACE_NONE,
    SPACE_INTERNAL_RAM,
    SPACE_SPECIAL_REG,
    SPACE_ONCHIP_XRAM,
    SPACE_EXTERNAL_BUS,
    SPACE_CODE
  } space_t;

endpackage

//--- stack_pointer_unit.sv
/*
  Stack pointer holder: 8 or 16 bit stack pointer with push/pop and load.
  Assumes the core issues at most one stack operation per machine cycle.
*/
`timescale 1ns/1ps
module stack_pointer_unit
  import mem_space_pkg::*;
(
  input wire logic clk,
  input wire logic rst,
  input wire logic wide_enable,
  input wire logic push,
  input wire logic pop,
  input wire logic load,
  input wire logic [SP_WIDTH-1:0] load_value,
  output logic [SP_WIDTH-1:0] sp
);

  typedef struct packed {
    logic [SP_WIDTH-1:0] sp;
  } sp_state_t;

  sp_state_t state;
  sp_state_t next_state;

  // ----------------------------------------------------------------
  // next value
  // ----------------------------------------------------------------
  always_comb
  begin
    next_state = state;
    if (load)
      next_state.sp = load_value;
    else if (push)
      next_state.sp = state.sp + 16'h0001;
    else if (pop)
      next_state.sp = state.sp - 16'h0001;
    // narrow stack wraps within the low 256 bytes
    if (!wide_enable)
      next_state.sp = {8'h00, next_state.sp[7:0]};
  end

  always_ff @(posedge clk)
  begin
    if (rst)
      state <= '{sp: SP_RESET[SP_WIDTH-1:0]};
    else
      state <= next_state;
  end

  assign sp = state.sp;

endmodule // stack_pointer_unit

//--- memory_space_decoder.sv
/*
  Memory space decoder: classifies each core access into a target space and
  routes it to internal ram, special registers, on-chip external ram, the
  external bus or code. Holds program counter, both data pointers and the
  stack pointer, and flags each machine cycle start on MCYCLE_START.
  Assumes access requests are synchronous to CLK_SYS and held for one cycle.
*/
`timescale 1ns/1ps

// Functional notes
// RULE_01: program counter is 23 bits wide, reaching the whole code space.
// RULE_02: separate 23-bit extended data pointer beside the 16-bit data pointer.
// RULE_03: one machine cycle lasts exactly six clock periods.
// RULE_04: direct and indirect reach internal ram 00h-7Fh; external/code moves never.
// RULE_05: indirect reaches internal ram 00h-FFh.
// RULE_06: 1280-byte extended ram; upper part only via stack or universal pointer.
// RULE_07: stack pointer widens to 16 bits when stack extension is enabled.
// RULE_08: special registers 80h-FFh only by direct; indirect goes to ram.
// RULE_09: external move via 16-bit pointer or indirect regs reaches 64 KB space; indirect regs reach only 00h-FFh here.
// RULE_10: on-chip external ram of 768 or 1792 bytes, can be disabled.
// RULE_11: external move via extended pointer reaches high data up to 8,323,072 bytes.
// RULE_12: high data outside on-chip portion goes to the external bus.
// RULE_13: code space up to 8 MB reached by fetch and code moves.
// RULE_14: universal pointer moves reach every space except special registers.
// RULE_15: extended addressing switches the external bus to its wide format.
// RULE_16: stack extension only when the stack extension enable bit is set.
// RULE_17: extended addressing needed for code or high data above 64 KB; universal pointer accesses here reach both without it.
// RULE_18: with on-chip external ram disabled, all external data goes off-chip.
module memory_space_decoder
  import mem_space_pkg::*;
#(
  parameter int XRAM_BYTES = XRAM_BYTES_SMALL
)
(
  input wire logic CLK_SYS,
  input wire logic RST,
  input wire logic STACK_EXTENSION_ENABLE,
  input wire logic EXTENDED_ADDRESS_ENABLE,
  input wire logic XRAM_DISABLE,
  input wire logic REQ_VALID,
  input wire access_class_t REQ_CLASS,
  input wire pointer_sel_t REQ_POINTER,
  input wire logic [7:0] REQ_OFFSET,
  input wire logic [7:0] INDIRECT_REG_ZERO,
  input wire logic [7:0] INDIRECT_REG_ONE,
  input wire logic [ADDR_WIDTH-1:0] UNIVERSAL_ADDR,
  input wire logic PC_LOAD,
  input wire logic PC_INCREMENT,
  input wire logic [PC_WIDTH-1:0] PC_VALUE,
  input wire logic DATA_POINTER_16_LOAD,
  input wire logic [DATA_POINTER_16_WIDTH-1:0] DATA_POINTER_16_VALUE,
  input wire logic EXTENDED_DATA_POINTER_LOAD,
  input wire logic [EXTENDED_DATA_POINTER_WIDTH-1:0] EXTENDED_DATA_POINTER_VALUE,
  input wire logic SP_PUSH,
  input wire logic SP_POP,
  input wire logic SP_LOAD,
  input wire logic [SP_WIDTH-1:0] SP_VALUE,
  output logic MCYCLE_START,
  output space_t ACC_SPACE,
  output logic [ADDR_WIDTH-1:0] ACC_ADDR,
  output logic ACC_VALID,
  output logic BUS_WIDE_FORMAT,
  output logic [PC_WIDTH-1:0] PC,
  output logic [SP_WIDTH-1:0] SP
);

  // refuse on-chip ram sizes other than the two built variants
  if (XRAM_BYTES != XRAM_BYTES_SMALL && XRAM_BYTES != XRAM_BYTES_LARGE)
  begin : g_bad_xram_size
    $error("XRAM_BYTES must be one of the two on-chip sizes");
  end

  localparam logic [22:0] XRAM_TOP = 23'(XRAM_BYTES - 1);
  localparam logic [22:0] EXTENDED_INTERNAL_SPACE_TOP = 23'(EXTENDED_INTERNAL_SPACE_BYTES - 1);

  typedef struct packed {
    logic [2:0] phase;
    logic [PC_WIDTH-1:0] pc;
    logic [DATA_POINTER_16_WIDTH-1:0] data_pointer_16;
    logic [EXTENDED_DATA_POINTER_WIDTH-1:0] extended_data_pointer;
    space_t space;
    logic [ADDR_WIDTH-1:0] addr;
    logic valid;
    logic wide;
  } state_t;

  state_t state;
  state_t next_state;
  logic [SP_WIDTH-1:0] sp;
  space_t dec_space;
  logic [ADDR_WIDTH-1:0] dec_addr;

  // ----------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------
  // external data: on-chip ram when enabled and in range, else the bus
  function automatic space_t external_data_space_target(input logic [22:0] a, input logic dis);
    if (!dis && a <= XRAM_TOP) // RULE_10 RULE_18
      return SPACE_ONCHIP_XRAM;
    return SPACE_EXTERNAL_BUS; // RULE_12
  endfunction

  // ----------------------------------------------------------------
  // stack pointer
  // ----------------------------------------------------------------
  stack_pointer_unit u_sp (
    .clk(CLK_SYS),
    .rst(RST),
    .wide_enable(STACK_EXTENSION_ENABLE), // RULE_07 RULE_16
    .push(SP_PUSH),
    .pop(SP_POP),
    .load(SP_LOAD),
    .load_value(SP_VALUE),
    .sp(sp)
  );

  // ----------------------------------------------------------------
  // space decode
  // ----------------------------------------------------------------
  always_comb
  begin
    dec_space = SPACE_NONE;
    dec_addr = '0;
    unique case (REQ_CLASS)
      ACC_DIRECT:
      begin
        dec_addr = {15'h0000, REQ_OFFSET};
        // upper half of direct space is special registers
        dec_space = (dec_addr <= DIRECT_TOP) ? SPACE_INTERNAL_RAM // RULE_04
                                             : SPACE_SPECIAL_REG; // RULE_08
      end
      ACC_INDIRECT:
      begin
        dec_addr = {15'h0000, REQ_OFFSET};
        dec_space = SPACE_INTERNAL_RAM; // RULE_05 RULE_08
      end
      ACC_STACK:
      begin
        dec_addr = {7'h00, sp};
        dec_space = (dec_addr <= EXTENDED_INTERNAL_SPACE_TOP) ? SPACE_INTERNAL_RAM // RULE_06
                                            : SPACE_NONE;
      end
      ACC_EXT_MOVE:
      begin
        unique case (REQ_POINTER)
          PTR_DPTR16: dec_addr = {7'h00, state.data_pointer_16}; // RULE_09
          PTR_REG_ZERO: dec_addr = {15'h0000, INDIRECT_REG_ZERO};
          PTR_REG_ONE: dec_addr = {15'h0000, INDIRECT_REG_ONE};
          PTR_EXTENDED: dec_addr = state.extended_data_pointer; // RULE_11
        endcase
        // high data above 64 KB is only reachable in extended addressing
        if (!EXTENDED_ADDRESS_ENABLE) // RULE_17
          dec_addr = {7'h00, dec_addr[15:0]};
        if (dec_addr < HIGH_DATA_SPACE_BYTES + EXTERNAL_DATA_SPACE_TOP + 23'h000001 - 23'h010000)
          dec_space = external_data_space_target(dec_addr, XRAM_DISABLE); // RULE_04
      end
      ACC_CODE_MOVE, ACC_FETCH:
      begin
        dec_addr = (REQ_CLASS == ACC_FETCH) ? state.pc : state.data_pointer_16 + 23'h000000;
        if (REQ_CLASS == ACC_CODE_MOVE && REQ_POINTER == PTR_EXTENDED)
          dec_addr = state.extended_data_pointer;
        if (!EXTENDED_ADDRESS_ENABLE) // RULE_17
          dec_addr = {7'h00, dec_addr[15:0]};
        dec_space = SPACE_CODE; // RULE_13
      end
      ACC_UNIVERSAL:
      begin
        // no path to special registers from a universal pointer
        if (UNIVERSAL_ADDR >= UPTR_EXTENDED_INTERNAL_SPACE_BASE) // RULE_14
        begin
          dec_addr = UNIVERSAL_ADDR - UPTR_EXTENDED_INTERNAL_SPACE_BASE;
          dec_space = (dec_addr <= EXTENDED_INTERNAL_SPACE_TOP) ? SPACE_INTERNAL_RAM : SPACE_NONE; // RULE_06
        end
        else if (UNIVERSAL_ADDR[22])
        begin
          dec_addr = UNIVERSAL_ADDR - 23'h400000;
          dec_space = external_data_space_target(dec_addr, XRAM_DISABLE);
        end
        else
        begin
          dec_addr = UNIVERSAL_ADDR;
          dec_space = SPACE_CODE;
        end
      end
      default:
      begin
        dec_space = SPACE_NONE;
        dec_addr = '0;
      end
    endcase
  end

  // ----------------------------------------------------------------
  // state update
  // ----------------------------------------------------------------
  always_comb
  begin
    next_state = state;
    next_state.phase = (state.phase == MCYCLE_LAST) ? 3'h0 : state.phase + 3'h1; // RULE_03
    if (PC_LOAD)
      next_state.pc = PC_VALUE; // RULE_01
    else if (PC_INCREMENT)
      next_state.pc = state.pc + 23'h000001;
    if (DATA_POINTER_16_LOAD)
      next_state.data_pointer_16 = DATA_POINTER_16_VALUE;
    if (EXTENDED_DATA_POINTER_LOAD)
      next_state.extended_data_pointer = EXTENDED_DATA_POINTER_VALUE; // RULE_02
    next_state.valid = REQ_VALID && (dec_space != SPACE_NONE);
    if (REQ_VALID)
    begin
      next_state.space = dec_space;
      next_state.addr = dec_addr;
    end
    // wide bus format whenever extended addressing is on
    next_state.wide = EXTENDED_ADDRESS_ENABLE; // RULE_15
  end

  always_ff @(posedge CLK_SYS)
  begin
    if (RST)
      state <= '{phase: 3'h0, pc: '0, data_pointer_16: '0, extended_data_pointer: '0, space: SPACE_NONE,
                 addr: '0, valid: 1'b0, wide: 1'b0};
    else
      state <= next_state;
  end

  assign MCYCLE_START = (state.phase == 3'h0);
  assign ACC_SPACE = state.space;
  assign ACC_ADDR = state.addr;
  assign ACC_VALID = state.valid;
  assign BUS_WIDE_FORMAT = state.wide;
  assign PC = state.pc;
  assign SP = sp;

endmodule // memory_space_decoder

//--- mem_space_properties.sv
/*
  Port checker for memory_space_decoder.
  Assumes it is bound to every decoder instance and sees its ports only.
*/
`timescale 1ns/1ps
module mem_space_properties
  import mem_space_pkg::*;
(
  input wire logic CLK_SYS,
  input wire logic RST,
  input wire logic EXTENDED_ADDRESS_ENABLE,
  input wire logic XRAM_DISABLE,
  input wire logic REQ_VALID,
  input wire access_class_t REQ_CLASS,
  input wire logic [7:0] REQ_OFFSET,
  input wire logic PC_LOAD,
  input wire logic PC_INCREMENT,
  input wire logic MCYCLE_START,
  input wire space_t ACC_SPACE,
  input wire logic ACC_VALID,
  input wire logic BUS_WIDE_FORMAT,
  input wire logic [PC_WIDTH-1:0] PC
);
  // ----------------------------------------------------------------
  // assertions
  // ----------------------------------------------------------------
  default clocking cb @(posedge CLK_SYS);
  endclocking
  default disable iff (RST);
  a_mcycle_six: assert property (MCYCLE_START |=> !MCYCLE_START [*5] ##1 MCYCLE_START)
    else $error("machine cycle length wrong");
  a_direct_low_ram: assert property (REQ_VALID && REQ_CLASS == ACC_DIRECT && !REQ_OFFSET[7]
    |=> ACC_VALID && ACC_SPACE == SPACE_INTERNAL_RAM) else $error("direct low not ram");
  a_direct_high_sfr: assert property (REQ_VALID && REQ_CLASS == ACC_DIRECT && REQ_OFFSET[7]
    |=> ACC_VALID && ACC_SPACE == SPACE_SPECIAL_REG) else $error("direct high not sfr");
  a_indirect_ram: assert property (REQ_VALID && REQ_CLASS == ACC_INDIRECT
    |=> ACC_VALID && ACC_SPACE == SPACE_INTERNAL_RAM) else $error("indirect not ram");
  a_ext_move_space: assert property (REQ_VALID && REQ_CLASS == ACC_EXT_MOVE
    |=> ACC_VALID && ACC_SPACE inside {SPACE_ONCHIP_XRAM, SPACE_EXTERNAL_BUS})
    else $error("external move wrong space");
  a_xram_off_bus: assert property (REQ_VALID && REQ_CLASS == ACC_EXT_MOVE && XRAM_DISABLE
    |=> ACC_SPACE == SPACE_EXTERNAL_BUS) else $error("disabled xram still used");
  a_code_reach: assert property (REQ_VALID && REQ_CLASS inside {ACC_FETCH, ACC_CODE_MOVE}
    |=> ACC_VALID && ACC_SPACE == SPACE_CODE) else $error("code access not code");
  a_univ_no_sfr: assert property (REQ_VALID && REQ_CLASS == ACC_UNIVERSAL
    |=> ACC_SPACE != SPACE_SPECIAL_REG) else $error("universal reached sfr");
  a_bus_format: assert property (1'b1
    |=> BUS_WIDE_FORMAT == $past(EXTENDED_ADDRESS_ENABLE)) else $error("bus format lag");
  a_pc_step: assert property (PC_INCREMENT && !PC_LOAD
    |=> PC == $past(PC) + 23'h1) else $error("pc step wrong");
  c_sfr: cover property (ACC_VALID && ACC_SPACE == SPACE_SPECIAL_REG);
  c_xram_off: cover property (REQ_VALID && REQ_CLASS == ACC_EXT_MOVE && XRAM_DISABLE);
  c_univ: cover property (REQ_VALID && REQ_CLASS == ACC_UNIVERSAL);
endmodule // mem_space_properties

bind memory_space_decoder mem_space_properties i_mem_space_properties (.CLK_SYS, .RST,
  .EXTENDED_ADDRESS_ENABLE, .XRAM_DISABLE, .REQ_VALID, .REQ_CLASS, .REQ_OFFSET, .PC_LOAD,
  .PC_INCREMENT, .MCYCLE_START, .ACC_SPACE, .ACC_VALID, .BUS_WIDE_FORMAT, .PC);

//--- ext_bus_model.sv
/*
  Off-chip memory side: counts bus accesses and flags wide addresses on a narrow bus.
  Assumes decoder outputs on the core clock.
*/
`timescale 1ns/1ps
module ext_bus_model
  import mem_space_pkg::*;
(
  input wire logic clk,
  input wire logic rst,
  input wire logic acc_valid,
  input wire space_t acc_space,
  input wire logic [ADDR_WIDTH-1:0] acc_addr,
  input wire logic wide_format,
  output int hits,
  output logic fmt_ok
);
  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      hits <= 0;
      fmt_ok <= 1'b1;
    end
    else if (acc_valid && acc_space == SPACE_EXTERNAL_BUS)
    begin
      hits <= hits + 1;
      if (acc_addr > EXTERNAL_DATA_SPACE_TOP && !wide_format)
        fmt_ok <= 1'b0;
    end
  end
endmodule // ext_bus_model

//--- tb_top.sv
/*
  Self-checking bench for memory_space_decoder.
  Assumes the checker is bound and the bus model sits on the outputs.
*/
`timescale 1ns/1ps
module tb_top
  import mem_space_pkg::*;
;
  logic clk, rst, see, eae, xdis, rv, pcl, pci, dl, el, spu, spo, spl, ms, av, bw, fmt_ok;
  access_class_t cls;
  pointer_sel_t ptr;
  space_t sp_o;
  logic [7:0] ofs;
  logic [22:0] ua, v23, aa, pc;
  logic [15:0] sp;
  int hits, n_errors, comparisons, n;
  memory_space_decoder #(.XRAM_BYTES(768)) i_memory_space_decoder (.CLK_SYS(clk),
    .RST(rst), .STACK_EXTENSION_ENABLE(see), .EXTENDED_ADDRESS_ENABLE(eae),
    .XRAM_DISABLE(xdis), .REQ_VALID(rv), .REQ_CLASS(cls), .REQ_POINTER(ptr),
    .REQ_OFFSET(ofs), .INDIRECT_REG_ZERO(ofs), .INDIRECT_REG_ONE(ofs),
    .UNIVERSAL_ADDR(ua), .PC_LOAD(pcl), .PC_INCREMENT(pci), .PC_VALUE(v23),
    .DATA_POINTER_16_LOAD(dl), .DATA_POINTER_16_VALUE(v23[15:0]), .EXTENDED_DATA_POINTER_LOAD(el), .EXTENDED_DATA_POINTER_VALUE(v23),
    .SP_PUSH(spu), .SP_POP(spo), .SP_LOAD(spl), .SP_VALUE(v23[15:0]),
    .MCYCLE_START(ms), .ACC_SPACE(sp_o), .ACC_ADDR(aa), .ACC_VALID(av),
    .BUS_WIDE_FORMAT(bw), .PC(pc), .SP(sp));
  ext_bus_model i_ext_bus_model (.clk(clk), .rst(rst), .acc_valid(av), .acc_space(sp_o),
    .acc_addr(aa), .wide_format(bw), .hits(hits), .fmt_ok(fmt_ok));
  // ----------------------------------------------------------------
  // tasks
  // ----------------------------------------------------------------
  task automatic chk(input logic [22:0] s, input logic [22:0] e);
    comparisons++;
    if (s !== e)
    begin
      n_errors++;
      $display("Error %0t: got %h exp %h", $time, s, e);
    end
  endtask
  task automatic rq(input access_class_t c, input pointer_sel_t p, input logic [7:0] o,
      input space_t s, input logic v, input logic [22:0] a);
    @(posedge clk);
    rv <= 1'b1;
    cls <= c;
    ptr <= p;
    ofs <= o;
    @(posedge clk);
    rv <= 1'b0;
    #1;
    chk(av, v);
    chk(sp_o, s);
    if (v)
      chk(aa, a);
  endtask
  // one-cycle pulse on {pc load, pc inc, data_pointer_16, extended_data_pointer, sp load, push} with value
  task automatic ld(input logic [5:0] m, input logic [22:0] v);
    @(posedge clk);
    {pcl, pci, dl, el, spl, spu} <= m;
    v23 <= v;
    @(posedge clk);
    {pcl, pci, dl, el, spl, spu} <= 6'h00;
    #1;
  endtask
  task automatic print_verdict;
    $display("n_errors %0d comparisons %0d", n_errors, comparisons);
    if (n_errors == 0 && comparisons > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask
  // ----------------------------------------------------------------
  // run
  // ----------------------------------------------------------------
  initial
  begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end
  initial
  begin
    repeat (5000) @(posedge clk);
    n_errors++;
    print_verdict;
  end
  initial
  begin
    {rst, see, eae, xdis, rv, pcl, pci, dl, el, spu, spo, spl} = 12'h800;
    cls = ACC_DIRECT;
    ptr = PTR_DPTR16;
    ofs = 8'h00;
    ua = 23'h000000;
    v23 = 23'h000000;
    repeat (12) @(posedge clk);
    rst <= 1'b0;
    #1;
    chk(pc, 23'h000000);
    chk(sp, 16'h0007);
    chk(sp_o, SPACE_NONE);
    n = 0;
    repeat (12)
    begin
      @(posedge clk);
      #1;
      n += ms;
    end
    chk(n, 2);
    rq(ACC_DIRECT, PTR_REG_ZERO, 8'h7f, SPACE_INTERNAL_RAM, 1'b1, 23'h7f);
    rq(ACC_DIRECT, PTR_REG_ZERO, 8'h80, SPACE_SPECIAL_REG, 1'b1, 23'h80);
    rq(ACC_INDIRECT, PTR_REG_ZERO, 8'h80, SPACE_INTERNAL_RAM, 1'b1, 23'h80);
    rq(ACC_INDIRECT, PTR_REG_ONE, 8'hff, SPACE_INTERNAL_RAM, 1'b1, 23'hff);
    ld(6'h08, 23'h0002ff);
    rq(ACC_EXT_MOVE, PTR_DPTR16, 8'h00, SPACE_ONCHIP_XRAM, 1'b1, 23'h2ff);
    ld(6'h08, 23'h000300);
    rq(ACC_EXT_MOVE, PTR_DPTR16, 8'h00, SPACE_EXTERNAL_BUS, 1'b1, 23'h300);
    rq(ACC_EXT_MOVE, PTR_REG_ZERO, 8'h10, SPACE_ONCHIP_XRAM, 1'b1, 23'h10);
    xdis <= 1'b1;
    rq(ACC_EXT_MOVE, PTR_REG_ONE, 8'h10, SPACE_EXTERNAL_BUS, 1'b1, 23'h10);
    xdis <= 1'b0;
    eae <= 1'b1;
    ld(6'h04, 23'h123456);
    rq(ACC_EXT_MOVE, PTR_EXTENDED, 8'h00, SPACE_EXTERNAL_BUS, 1'b1, 23'h123456);
    chk(bw, 1'b1);
    // the bus model counts on the edge after the access is shown
    @(posedge clk);
    #1;
    chk(fmt_ok, 1'b1);
    chk(hits, 3);
    rq(ACC_CODE_MOVE, PTR_EXTENDED, 8'h00, SPACE_CODE, 1'b1, 23'h123456);
    ld(6'h20, 23'h7ffffe);
    ld(6'h10, 23'h000000);
    chk(pc, 23'h7fffff);
    rq(ACC_FETCH, PTR_DPTR16, 8'h00, SPACE_CODE, 1'b1, 23'h7fffff);
    ua <= 23'h7f04ff;
    rq(ACC_UNIVERSAL, PTR_DPTR16, 8'h00, SPACE_INTERNAL_RAM, 1'b1, 23'h4ff);
    ua <= 23'h7f0500;
    rq(ACC_UNIVERSAL, PTR_DPTR16, 8'h00, SPACE_NONE, 1'b0, 23'h0);
    ua <= 23'h000200;
    rq(ACC_UNIVERSAL, PTR_DPTR16, 8'h00, SPACE_CODE, 1'b1, 23'h200);
    ld(6'h02, 23'h0000ff);
    ld(6'h01, 23'h000000);
    chk(sp, 16'h0000);
    see <= 1'b1;
    ld(6'h02, 23'h0000ff);
    ld(6'h01, 23'h000000);
    chk(sp, 16'h0100);
    eae <= 1'b0;
    rq(ACC_EXT_MOVE, PTR_EXTENDED, 8'h00, SPACE_EXTERNAL_BUS, 1'b1, 23'h003456);
    print_verdict;
  end
endmodule // tb_top
